// ---- src/dpcf_top.sv ----
// Performance counter filter: two 32-bit statistics counters, their
// event selection and master/space filters, and an APB register port.
// Assumes event inputs come from controller logic on sys_clk.
//
// Functional notes
// - Counter two master filter bit 31: off counts all, on matches master ID.
// - Counter one master filter bit 15: off counts all, on matches master ID.
// - Counter two space filter bit 30 off: count every access, ignore select.
// - Counter two space filter on: select 0 SDRAM only, 7h registers only.
// - Counter one space filter bit 14 off: count every access, ignore select.
// - Counter one space filter on: select 0 SDRAM only, 7h registers only.
// - Select register: IDs at 31-24 and 15-8, spaces at 19-16 and 3-0.
// - Config register: event selects at bits 19-16 and 3-0.
// - Selection 0 counts all read and write commands received.
// - Commands add transfer size divided by the default burst size, rounded up.
// - Selection 1h counts activates, one per request to a closed bank.
// - Selection 2h counts read commands in burst-size pieces.
// - Selection 3h counts write commands in burst-size pieces.
// - Selection 4h adds one each cycle the command queue is full.
// - Selection 8h counts queued commands needing priority elevation.
// - Oldest queued command is raised after the starvation transfer count.
// - Selection 9h adds one each cycle the command queue is not empty.
// - Both counters are 32-bit read-only values steered by the two registers.
// - Counters clear only on module reset.
`timescale 1ns/1ps
`default_nettype none

module dpcf_top (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output var logic [31:0] prdata,
  output var logic pready,
  output var logic pslverr,
  // Controller events.
  input wire dpcf_pkg::dpcf_event_type ctl_events,
  // Counter values.
  output var logic [31:0] stat_counter_one,
  output var logic [31:0] stat_counter_two
);

  logic [31:0] config_q;
  logic [31:0] config_d;
  logic [31:0] select_q;
  logic [31:0] select_d;
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic [31:0] cnt_q [2];
  logic [31:0] cnt_d [2];
  dpcf_pkg::dpcf_cnt_cfg_type cfg [2];
  logic wr_fire;
  logic rd_start;

  function automatic logic addr_mapped(input logic [11:0] addr);
    addr_mapped = (addr == dpcf_pkg::OFS_CONFIG) ||
                  (addr == dpcf_pkg::OFS_SELECT) ||
                  (addr == dpcf_pkg::OFS_COUNT_ONE) ||
                  (addr == dpcf_pkg::OFS_COUNT_TWO);
  endfunction

  // Unpacks one counter's settings from the two registers.
  function automatic dpcf_pkg::dpcf_cnt_cfg_type unpack_cfg(
    input logic [31:0] conf,
    input logic [31:0] sel,
    input logic two
  );
    dpcf_pkg::dpcf_cnt_cfg_type c;
    if (two) begin
      c.event_sel = conf[dpcf_pkg::POS_TWO_EVENT +: 4];
      c.master_en = conf[dpcf_pkg::POS_TWO_MASTER_EN];
      c.space_en = conf[dpcf_pkg::POS_TWO_SPACE_EN];
      c.master_id = sel[dpcf_pkg::POS_TWO_ID +: 8];
      c.space_sel = sel[dpcf_pkg::POS_TWO_SPACE +: 4];
    end else begin
      c.event_sel = conf[dpcf_pkg::POS_ONE_EVENT +: 4];
      c.master_en = conf[dpcf_pkg::POS_ONE_MASTER_EN];
      c.space_en = conf[dpcf_pkg::POS_ONE_SPACE_EN];
      c.master_id = sel[dpcf_pkg::POS_ONE_ID +: 8];
      c.space_sel = sel[dpcf_pkg::POS_ONE_SPACE +: 4];
    end
    return c;
  endfunction

  // Master and space filter; with the space filter on, a reserved space select passes nothing.
  function automatic logic source_ok(
    input dpcf_pkg::dpcf_cnt_cfg_type c,
    input logic [7:0] master,
    input logic reg_space
  );
    logic master_ok;
    logic space_ok;
    master_ok = !c.master_en || (master == c.master_id);
    space_ok = !c.space_en ||
               ((c.space_sel == dpcf_pkg::SPACE_SDRAM) && !reg_space) ||
               ((c.space_sel == dpcf_pkg::SPACE_REGS) && reg_space);
    return master_ok && space_ok;
  endfunction

  // Amount one counter advances by in the current cycle.
  function automatic logic [31:0] count_step(
    input dpcf_pkg::dpcf_cnt_cfg_type c,
    input dpcf_pkg::dpcf_event_type ev
  );
    logic [31:0] step;
    logic [12:0] rounded;
    logic [31:0] pieces;
    logic cmd_ok;
    step = 32'h0000_0000;
    rounded = {1'b0, ev.cmd_size} + dpcf_pkg::BURST_ROUND;
    pieces = 32'(rounded >> dpcf_pkg::BURST_LOG2);
    cmd_ok = ev.cmd_valid && source_ok(c, ev.cmd_master, ev.cmd_reg_space);
    case (c.event_sel)
      dpcf_pkg::EV_RDWR: begin
        if (cmd_ok) begin
          step = pieces;
        end
      end
      dpcf_pkg::EV_ACT: begin
        if (ev.activate) begin
          step = 32'h0000_0001;
        end
      end
      dpcf_pkg::EV_READ: begin
        if (cmd_ok && !ev.cmd_write) begin
          step = pieces;
        end
      end
      dpcf_pkg::EV_WRITE: begin
        if (cmd_ok && ev.cmd_write) begin
          step = pieces;
        end
      end
      dpcf_pkg::EV_FULL: begin
        if (ev.queue_full) begin
          step = 32'h0000_0001;
        end
      end
      dpcf_pkg::EV_ELEV: begin
        // The scheduler pulses elev_valid when it raises the oldest command.
        if (ev.elev_valid &&
            source_ok(c, ev.elev_master, ev.elev_reg_space)) begin
          step = 32'h0000_0001;
        end
      end
      dpcf_pkg::EV_BUSY: begin
        if (ev.queue_busy) begin
          step = 32'h0000_0001;
        end
      end
      default: begin
        step = 32'h0000_0000;
      end
    endcase
    return step;
  endfunction

  assign cfg[0] = unpack_cfg(config_q, select_q, 1'b0);
  assign cfg[1] = unpack_cfg(config_q, select_q, 1'b1);

  // A request is answered on the second access-phase edge.
  assign rd_start = psel && penable && !pready_q;
  assign wr_fire = psel && penable && pready_q && pwrite;

  always_comb begin
    pready_d = rd_start;
    pslverr_d = rd_start && !addr_mapped(paddr);
    prdata_d = 32'h0000_0000;
    if (rd_start && !pwrite) begin
      case (paddr)
        dpcf_pkg::OFS_CONFIG: prdata_d = config_q;
        dpcf_pkg::OFS_SELECT: prdata_d = select_q;
        dpcf_pkg::OFS_COUNT_ONE: prdata_d = cnt_q[0];
        dpcf_pkg::OFS_COUNT_TWO: prdata_d = cnt_q[1];
        default: prdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  // Reserved bits are dropped on write and read back as zero.
  always_comb begin
    config_d = config_q;
    select_d = select_q;
    if (wr_fire && (paddr == dpcf_pkg::OFS_CONFIG)) begin
      config_d = pwdata & dpcf_pkg::CONFIG_MASK;
    end
    if (wr_fire && (paddr == dpcf_pkg::OFS_SELECT)) begin
      select_d = pwdata & dpcf_pkg::SELECT_MASK;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      config_q <= dpcf_pkg::CONFIG_RESET;
      select_q <= dpcf_pkg::SELECT_RESET;
    end else begin
      config_q <= config_d;
      select_q <= select_d;
    end
  end

  // Counters are read-only; the sum wraps modulo two to the 32nd.
  for (genvar i = 0; i < 2; i++) begin : g_cnt
    always_comb begin
      cnt_d[i] = cnt_q[i] + count_step(cfg[i], ctl_events);
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        cnt_q[i] <= dpcf_pkg::COUNT_RESET;
      end else begin
        cnt_q[i] <= cnt_d[i];
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign stat_counter_one = cnt_q[0];
  assign stat_counter_two = cnt_q[1];

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  sequence apb_cfg_write_s;
    psel && penable && pready_q && pwrite && (paddr == dpcf_pkg::OFS_CONFIG);
  endsequence

  sequence quiet_cmd_s;
    !ctl_events.elev_valid && !ctl_events.activate;
  endsequence

  master_two_a: assert property (
    (cfg[1].master_en && (cfg[1].event_sel == dpcf_pkg::EV_RDWR) &&
     !(ctl_events.cmd_valid &&
       (ctl_events.cmd_master == cfg[1].master_id)))
    |=> (cnt_q[1] == $past(cnt_q[1])))
    else $error("counter two moved for a filtered master");

  master_one_a: assert property (
    (cfg[0].master_en && !cfg[0].space_en &&
     (cfg[0].event_sel == dpcf_pkg::EV_RDWR) && ctl_events.cmd_valid &&
     (ctl_events.cmd_master == cfg[0].master_id) &&
     (ctl_events.cmd_size == 12'h010))
    |=> (cnt_q[0] == $past(cnt_q[0]) + 32'h0000_0001))
    else $error("counter one missed a matching master command");

  space_off_a: assert property (
    (!cfg[1].space_en && !cfg[1].master_en &&
     (cfg[1].event_sel == dpcf_pkg::EV_RDWR) && ctl_events.cmd_valid &&
     ctl_events.cmd_reg_space && (ctl_events.cmd_size == 12'h010))
    |=> (cnt_q[1] == $past(cnt_q[1]) + 32'h0000_0001))
    else $error("counter two dropped a register access");

  space_two_a: assert property (
    (cfg[1].space_en && (cfg[1].space_sel == dpcf_pkg::SPACE_REGS) &&
     (cfg[1].event_sel == dpcf_pkg::EV_RDWR) && !ctl_events.cmd_reg_space)
    |=> (cnt_q[1] == $past(cnt_q[1])))
    else $error("counter two counted SDRAM under register space");

  space_one_a: assert property (
    (cfg[0].space_en && (cfg[0].space_sel == dpcf_pkg::SPACE_SDRAM) &&
     (cfg[0].event_sel == dpcf_pkg::EV_RDWR) && ctl_events.cmd_reg_space)
    |=> (cnt_q[0] == $past(cnt_q[0])))
    else $error("counter one counted a register access under SDRAM");

  activate_one_a: assert property (
    ((cfg[0].event_sel == dpcf_pkg::EV_ACT) && ctl_events.activate)
    |=> (cnt_q[0] == $past(cnt_q[0]) + 32'h0000_0001))
    else $error("activate not counted once");

  full_wrap_a: assert property (
    ((((cfg[1].event_sel == dpcf_pkg::EV_FULL) &&
       ctl_events.queue_full) [*2])
     and (quiet_cmd_s [*2]))
    |=> (cnt_q[1] == $past(cnt_q[1], 2) + 32'h0000_0002))
    else $error("full cycles not counted one per cycle");

  busy_wrap_a: assert property (
    ((cfg[0].event_sel == dpcf_pkg::EV_BUSY) && ctl_events.queue_busy)
    |=> (cnt_q[0] == $past(cnt_q[0]) + 32'h0000_0001))
    else $error("counter one did not step modulo two to the 32nd");

  reserved_sel_a: assert property (
    ((cfg[0].event_sel inside {[4'h5:4'h7], [4'ha:4'hf]}) &&
     !$changed(config_q))
    |=> $stable(cnt_q[0]))
    else $error("reserved selection moved counter one");

  elev_two_a: assert property (
    ((cfg[1].event_sel == dpcf_pkg::EV_ELEV) && !cfg[1].master_en &&
     !cfg[1].space_en && ctl_events.elev_valid)
    |=> (cnt_q[1] == $past(cnt_q[1]) + 32'h0000_0001))
    else $error("priority elevation not counted");

  cfg_write_a: assert property (
    apb_cfg_write_s
    |=> ((cfg[1].event_sel == $past(pwdata[19:16])) &&
         (config_q[29:20] == 10'h000) && (config_q[13:4] == 10'h000)))
    else $error("config write did not land in the event fields");

endmodule

`default_nettype wire

// ---- src/dpcf_pkg.sv ----
// Constants, field layout and carrier types of the memory controller's
// performance counter filter block.
// Assumes one memory clock domain and an APB register port.
package dpcf_pkg;

  // Register byte offsets on the APB port.
  localparam logic [11:0] OFS_CONFIG = 12'h000;
  localparam logic [11:0] OFS_SELECT = 12'h004;
  localparam logic [11:0] OFS_COUNT_ONE = 12'h008;
  localparam logic [11:0] OFS_COUNT_TWO = 12'h00c;

  // Field positions in the filter configuration register.
  localparam int unsigned POS_TWO_MASTER_EN = 31;
  localparam int unsigned POS_TWO_SPACE_EN = 30;
  localparam int unsigned POS_TWO_EVENT = 16;
  localparam int unsigned POS_ONE_MASTER_EN = 15;
  localparam int unsigned POS_ONE_SPACE_EN = 14;
  localparam int unsigned POS_ONE_EVENT = 0;

  // Field positions in the master and space select register.
  localparam int unsigned POS_TWO_ID = 24;
  localparam int unsigned POS_TWO_SPACE = 16;
  localparam int unsigned POS_ONE_ID = 8;
  localparam int unsigned POS_ONE_SPACE = 0;

  // Values after reset and writable bit masks.
  localparam logic [31:0] CONFIG_RESET = 32'h0001_0000;
  localparam logic [31:0] SELECT_RESET = 32'h0000_0000;
  localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
  localparam logic [31:0] CONFIG_MASK = 32'hc00f_c00f;
  localparam logic [31:0] SELECT_MASK = 32'hff0f_ff0f;

  // Event selections.
  localparam logic [3:0] EV_RDWR = 4'h0;
  localparam logic [3:0] EV_ACT = 4'h1;
  localparam logic [3:0] EV_READ = 4'h2;
  localparam logic [3:0] EV_WRITE = 4'h3;
  localparam logic [3:0] EV_FULL = 4'h4;
  localparam logic [3:0] EV_ELEV = 4'h8;
  localparam logic [3:0] EV_BUSY = 4'h9;

  // Space selections.
  localparam logic [3:0] SPACE_SDRAM = 4'h0;
  localparam logic [3:0] SPACE_REGS = 4'h7;

  // Default burst size is 2**BURST_LOG2 bytes; sizes are in bytes.
  localparam int unsigned BURST_LOG2 = 4;
  localparam logic [12:0] BURST_ROUND = 13'h000f;

  typedef struct packed {
    logic [3:0] event_sel;
    logic master_en;
    logic space_en;
    logic [7:0] master_id;
    logic [3:0] space_sel;
  } dpcf_cnt_cfg_type;

  // Events reported by the controller core in the memory clock domain.
  typedef struct packed {
    logic cmd_valid;
    logic cmd_write;
    logic cmd_reg_space;
    logic [7:0] cmd_master;
    logic [11:0] cmd_size;
    logic activate;
    logic queue_full;
    logic queue_busy;
    logic elev_valid;
    logic elev_reg_space;
    logic [7:0] elev_master;
  } dpcf_event_type;

endpackage

// ---- tb/dpcf_masters_model.sv ----
// Model of the bus masters and command queue that feed controller events.
// Assumes the same sys_clk as the block and is driven through its task.
`timescale 1ns/1ps
`default_nettype none

module dpcf_masters_model (
  // Clock.
  input wire logic sys_clk,
  // Events towards the block.
  output var dpcf_pkg::dpcf_event_type ctl_events
);
  initial ctl_events = '0;

  // Holds one event pattern for n cycles, then goes idle.
  task automatic hold(input dpcf_pkg::dpcf_event_type ev, input int n);
    dpcf_pkg::dpcf_event_type idle;
    // Idle payload is inverted so stale command fields never look valid.
    idle = ~ev;
    idle.cmd_valid = 1'b0;
    idle.activate = 1'b0;
    idle.queue_full = 1'b0;
    idle.queue_busy = 1'b0;
    idle.elev_valid = 1'b0;
    repeat (n) begin
      @(posedge sys_clk);
      ctl_events <= ev;
    end
    @(posedge sys_clk);
    ctl_events <= idle;
  endtask
endmodule

`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench of the counter filter block over APB.
// Assumes one 100 MHz clock and the masters model as event source.
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  dpcf_pkg::dpcf_event_type ctl_events;
  logic [31:0] stat_counter_one;
  logic [31:0] stat_counter_two;
  logic [31:0] r_data;
  logic r_err;
  logic [31:0] e1 = 32'h0000_0000;
  logic [31:0] e2 = 32'h0000_0000;
  dpcf_pkg::dpcf_event_type ev;
  int err_count = 0;
  int checks_done = 0;

  always #5 sys_clk = ~sys_clk;

  dpcf_top i_dpcf_top (
    .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ctl_events(ctl_events),
    .stat_counter_one(stat_counter_one),
    .stat_counter_two(stat_counter_two)
  );

  dpcf_masters_model u_masters (.sys_clk(sys_clk), .ctl_events(ctl_events));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      chk(32'h0000_0000, 32'h0000_0001);
    end
    r_data = prdata;
    r_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(r_data, exp);
  endtask

  function automatic dpcf_pkg::dpcf_event_type cmd(input logic wr,
      input logic rs, input logic [7:0] m, input logic [11:0] sz);
    cmd = '0;
    cmd.cmd_valid = 1'b1;
    cmd.cmd_write = wr;
    cmd.cmd_reg_space = rs;
    cmd.cmd_master = m;
    cmd.cmd_size = sz;
  endfunction

  // Sends one pattern, lets the counters update, then compares both.
  task automatic send(input dpcf_pkg::dpcf_event_type e, input int n);
    u_masters.hold(e, n);
    @(posedge sys_clk);
    #1;
    chk(stat_counter_one, e1);
    chk(stat_counter_two, e2);
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #100000;
    err_count++;
    complete_run();
  end

  initial begin
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(dpcf_pkg::OFS_CONFIG, 32'h0001_0000);
    rd(dpcf_pkg::OFS_SELECT, 32'h0000_0000);
    rd(dpcf_pkg::OFS_COUNT_ONE, 32'h0000_0000);
    apb(1'b1, dpcf_pkg::OFS_CONFIG, 32'hffff_ffff);
    rd(dpcf_pkg::OFS_CONFIG, 32'hc00f_c00f);
    apb(1'b1, dpcf_pkg::OFS_SELECT, 32'hffff_ffff);
    rd(dpcf_pkg::OFS_SELECT, 32'hff0f_ff0f);
    apb(1'b1, dpcf_pkg::OFS_COUNT_TWO, 32'h0000_0005);
    rd(dpcf_pkg::OFS_COUNT_TWO, 32'h0000_0000);
    rd(12'h010, 32'h0000_0000);
    chk({31'h0, r_err}, 32'h0000_0001);
    $display("test registers done");
    // Read and write selections split commands into 16 byte bursts.
    apb(1'b1, dpcf_pkg::OFS_CONFIG, 32'h0003_0002);
    apb(1'b1, dpcf_pkg::OFS_SELECT, 32'h0000_0000);
    e1 = e1 + 32'h4;
    send(cmd(1'b0, 1'b0, 8'h01, 12'h040), 1);
    e2 = e2 + 32'h3;
    send(cmd(1'b1, 1'b0, 8'h02, 12'h028), 1);
    send(cmd(1'b1, 1'b0, 8'h02, 12'h000), 1);
    e1 = e1 + 32'h1;
    send(cmd(1'b0, 1'b1, 8'h03, 12'h010), 1);
    $display("test read write done");
    apb(1'b1, dpcf_pkg::OFS_SELECT, 32'h3400_1200);
    apb(1'b1, dpcf_pkg::OFS_CONFIG, 32'h8000_8000);
    e1 = e1 + 32'h1;
    send(cmd(1'b1, 1'b0, 8'h12, 12'h010), 1);
    e2 = e2 + 32'h1;
    send(cmd(1'b0, 1'b0, 8'h34, 12'h010), 1);
    send(cmd(1'b1, 1'b0, 8'h55, 12'h010), 1);
    $display("test master filter done");
    apb(1'b1, dpcf_pkg::OFS_SELECT, 32'h0007_0000);
    apb(1'b1, dpcf_pkg::OFS_CONFIG, 32'h4000_4000);
    e1 = e1 + 32'h2;
    send(cmd(1'b0, 1'b0, 8'h09, 12'h020), 1);
    e2 = e2 + 32'h1;
    send(cmd(1'b0, 1'b1, 8'h09, 12'h010), 1);
    apb(1'b1, dpcf_pkg::OFS_CONFIG, 32'h0000_0000);
    e1 = e1 + 32'h1;
    e2 = e2 + 32'h1;
    send(cmd(1'b1, 1'b1, 8'h09, 12'h010), 1);
    $display("test space filter done");
    apb(1'b1, dpcf_pkg::OFS_CONFIG, 32'h0004_0001);
    ev = '0;
    ev.activate = 1'b1;
    e1 = e1 + 32'h3;
    send(ev, 3);
    ev = '0;
    ev.queue_full = 1'b1;
    e2 = e2 + 32'h5;
    send(ev, 5);
    apb(1'b1, dpcf_pkg::OFS_CONFIG, 32'h0008_0009);
    ev = '0;
    ev.queue_busy = 1'b1;
    e1 = e1 + 32'h4;
    send(ev, 4);
    ev = '0;
    ev.elev_valid = 1'b1;
    ev.elev_master = 8'h21;
    e2 = e2 + 32'h2;
    send(ev, 2);
    $display("test queue events done");
    apb(1'b1, dpcf_pkg::OFS_CONFIG, 32'h0005_000a);
    ev = cmd(1'b0, 1'b0, 8'h01, 12'h040);
    ev.activate = 1'b1;
    ev.queue_full = 1'b1;
    ev.queue_busy = 1'b1;
    ev.elev_valid = 1'b1;
    send(ev, 2);
    $display("test reserved select done");
    // A reset in mid-run must bring both counters and the config back.
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    e1 = 32'h0000_0000;
    e2 = 32'h0000_0000;
    rd(dpcf_pkg::OFS_COUNT_ONE, e1);
    rd(dpcf_pkg::OFS_COUNT_TWO, e2);
    rd(dpcf_pkg::OFS_CONFIG, 32'h0001_0000);
    $display("test reset done");
    complete_run();
  end
endmodule

`default_nettype wire
